//--- status_out_pkg.sv
package status_out_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int TIMER_W = 16;
  localparam int CFG_W = 4;
  localparam int ST_W = 6;
  localparam int EV_W = 4;
  localparam int CODE_W = 3;

  localparam logic [ADDR_W-1:0] OFF_CFG_STAGED = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CFG_ACTIVE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_BRAKE_TIME = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_STATE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h18;

  localparam int CFG_BRAKE_POL = 0;
  localparam int CFG_READY_POL = 1;
  localparam int CFG_WARN_POL = 2;
  localparam int CFG_FUNC_SEL = 3;

  localparam int ST_RELEASE = 0;
  localparam int ST_READY = 1;
  localparam int ST_WARN = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_BRAKE_DELAY = 4;
  localparam int ST_ERR_HOLD = 5;

  localparam int EV_FAULT = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_WARN = 2;
  localparam int EV_READY_LOST = 3;

  localparam int CTRL_RESTART = 0;

  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
  localparam logic [TIMER_W-1:0] BRAKE_TIME_RESET = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_HOLD_S = 2;
  localparam int TICKS_PER_S = 1000;
  localparam int ERR_HOLD_TICKS = ERR_HOLD_S * TICKS_PER_S;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
endpackage

//--- timer_if.sv
`timescale 1ns/1ns
interface timer_if;
  import status_out_pkg::*;
  logic start;
  logic [TIMER_W-1:0] load;
  logic busy;
  modport ctl (output start, output load, input busy);
  modport tmr (input start, input load, output busy);
endinterface

//--- hold_timer.sv
`timescale 1ns/1ns
module hold_timer #(
  parameter int TICK_CYCLES = status_out_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  timer_if.tmr t
);
  import status_out_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic [TIMER_W-1:0] rem_q;
  logic [31:0] pre_q;

  // A new start always reloads, even mid-count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rem_q <= '0;
      pre_q <= '0;
    end else if (t.start) begin
      rem_q <= t.load;
      pre_q <= '0;
    end else if (rem_q != '0) begin
      if (pre_q == TICK_LAST) begin
        pre_q <= '0;
        rem_q <= rem_q - TIMER_W'(1);
      end else begin
        pre_q <= pre_q + 32'h1;
      end
    end
  end

  assign t.busy = (rem_q != '0);

  chk_timer_reload: assert property (@(posedge clk) disable iff (!nrst)
    t.start |=> (rem_q == $past(t.load)) && (pre_q == 32'h0))
    else $error("timer did not reload on start");

  chk_timer_step: assert property (@(posedge clk) disable iff (!nrst)
    (!t.start && rem_q != '0 && pre_q != TICK_LAST) |=> $stable(rem_q))
    else $error("timer stepped before a full tick");
endmodule

//--- drive_status_outputs.sv
`timescale 1ns/1ns
module drive_status_outputs #(
  parameter int TICK_CYCLES = status_out_pkg::TICK_CYCLES,
  parameter int ERR_HOLD_TICKS = status_out_pkg::ERR_HOLD_TICKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [status_out_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [status_out_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [status_out_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic servo_fault_flag,
  input wire logic motor_power_on,
  input wire logic main_power_on,
  input wire logic hw_base_block,
  input wire logic error_event,
  input wire logic warning_active,
  input wire logic [status_out_pkg::CODE_W-1:0] alarm_code,
  output logic warn_pin_closed,
  output logic brake_pin_closed,
  output logic ready_pin_closed
);
  import status_out_pkg::*;

  localparam logic [TIMER_W-1:0] ERR_LOAD = TIMER_W'(ERR_HOLD_TICKS);
  localparam logic [31:0] HOLD_CYC = 32'(ERR_HOLD_TICKS * TICK_CYCLES);
  localparam logic [31:0] SINCE_MAX = HOLD_CYC + 32'h3;

  bus_state_t bus_q;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] readdata_q;
  logic bus_fire;
  logic wr_fire;
  logic restart_pulse;

  logic [CFG_W-1:0] cfg_staged_q;
  logic [CFG_W-1:0] cfg_active_q;
  logic [TIMER_W-1:0] brake_time_q;
  logic [EV_W-1:0] irq_status_q;
  logic [EV_W-1:0] irq_mask_q;
  logic [EV_W-1:0] irq_clr;
  logic [EV_W-1:0] ev;

  logic motor_on_q;
  logic fault_q;
  logic warn_in_q;
  logic release_d;
  logic release_q;
  logic ready_d;
  logic ready_q;
  logic warn_ind_d;
  logic warn_ind_q;
  logic [ST_W-1:0] state_word;

  logic warn_pin_q;
  logic brake_pin_q;
  logic ready_pin_q;

  timer_if brake_tmr ();
  timer_if err_tmr ();

  // Bus slave: one wait cycle per access, so read data come from a flop
  assign waitrequest = (read || write) && (bus_q == BUS_IDLE);
  assign bus_fire = (read || write) && (bus_q == BUS_ACK);
  assign wr_fire = write && bus_fire;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (read || write) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (address)
      OFF_CFG_STAGED: rd_mux[CFG_W-1:0] = cfg_staged_q;
      OFF_CFG_ACTIVE: rd_mux[CFG_W-1:0] = cfg_active_q;
      OFF_BRAKE_TIME: rd_mux[TIMER_W-1:0] = brake_time_q;
      OFF_STATE: rd_mux[ST_W-1:0] = state_word;
      OFF_IRQ_STATUS: rd_mux[EV_W-1:0] = irq_status_q;
      OFF_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_q <= '0;
    end else if (read && bus_q == BUS_IDLE) begin
      readdata_q <= rd_mux;
    end
  end

  assign readdata = readdata_q;

  // Staged settings only reach the pins through a restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_staged_q <= CFG_RESET;
    end else if (wr_fire && address == OFF_CFG_STAGED && byteenable[0]) begin
      cfg_staged_q <= writedata[CFG_W-1:0];
    end
  end

  assign restart_pulse = wr_fire && (address == OFF_CTRL) && byteenable[0]
                         && writedata[CTRL_RESTART];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_active_q <= CFG_RESET;
    end else if (restart_pulse) begin
      cfg_active_q <= cfg_staged_q;
    end
  end

  // Brake delay acts at once, as it only shapes the next power-off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brake_time_q <= BRAKE_TIME_RESET;
    end else if (wr_fire && address == OFF_BRAKE_TIME) begin
      if (byteenable[0]) begin
        brake_time_q[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        brake_time_q[15:8] <= writedata[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= MASK_RESET;
    end else if (wr_fire && address == OFF_IRQ_MASK && byteenable[0]) begin
      irq_mask_q <= writedata[EV_W-1:0];
    end
  end

  assign irq_clr = (wr_fire && address == OFF_IRQ_STATUS && byteenable[0])
                   ? writedata[EV_W-1:0] : '0;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | ev;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motor_on_q <= 1'b0;
      fault_q <= 1'b0;
      warn_in_q <= 1'b0;
    end else begin
      motor_on_q <= motor_power_on;
      fault_q <= servo_fault_flag;
      warn_in_q <= warning_active;
    end
  end

  always_comb begin
    ev = '0;
    ev[EV_FAULT] = servo_fault_flag && !fault_q;
    ev[EV_ERROR] = error_event;
    ev[EV_WARN] = warning_active && !warn_in_q;
    ev[EV_READY_LOST] = ready_q && !ready_d;
  end

  // Delay starts at the power-off edge; a fault overrides it
  assign brake_tmr.start = !motor_power_on && motor_on_q && !servo_fault_flag;
  assign brake_tmr.load = brake_time_q;

  hold_timer #(.TICK_CYCLES(TICK_CYCLES)) u_brake_timer (
    .clk(clk),
    .nrst(nrst),
    .t(brake_tmr.tmr)
  );

  assign err_tmr.start = error_event;
  assign err_tmr.load = ERR_LOAD;

  hold_timer #(.TICK_CYCLES(TICK_CYCLES)) u_err_timer (
    .clk(clk),
    .nrst(nrst),
    .t(err_tmr.tmr)
  );

  // motor_on_q bridges the cycle before the delay timer shows busy
  assign release_d = !servo_fault_flag
                     && (motor_power_on || motor_on_q || brake_tmr.busy);
  assign ready_d = main_power_on && !hw_base_block && !servo_fault_flag;
  assign warn_ind_d = warning_active || err_tmr.busy;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      release_q <= 1'b0;
      ready_q <= 1'b0;
      warn_ind_q <= 1'b0;
    end else begin
      release_q <= release_d;
      ready_q <= ready_d;
      warn_ind_q <= warn_ind_d;
    end
  end

  // Alarm code pins carry no polarity inversion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn_pin_q <= 1'b0;
      brake_pin_q <= 1'b0;
      ready_pin_q <= 1'b0;
    end else if (cfg_active_q[CFG_FUNC_SEL]) begin
      warn_pin_q <= alarm_code[0];
      brake_pin_q <= alarm_code[1];
      ready_pin_q <= alarm_code[2];
    end else begin
      warn_pin_q <= warn_ind_d ^ cfg_active_q[CFG_WARN_POL];
      brake_pin_q <= release_d ^ cfg_active_q[CFG_BRAKE_POL];
      ready_pin_q <= ready_d ^ cfg_active_q[CFG_READY_POL];
    end
  end

  assign warn_pin_closed = warn_pin_q;
  assign brake_pin_closed = brake_pin_q;
  assign ready_pin_closed = ready_pin_q;

  always_comb begin
    state_word = '0;
    state_word[ST_RELEASE] = release_q;
    state_word[ST_READY] = ready_q;
    state_word[ST_WARN] = warn_ind_q;
    state_word[ST_FAULT] = fault_q;
    state_word[ST_BRAKE_DELAY] = brake_tmr.busy;
    state_word[ST_ERR_HOLD] = err_tmr.busy;
  end

  // Cycles since the last error event, saturating; read only by checks
  logic [31:0] since_err_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_err_q <= SINCE_MAX;
    end else if (error_event) begin
      since_err_q <= 32'h1;
    end else if (since_err_q != SINCE_MAX) begin
      since_err_q <= since_err_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence power_gone_s;
    !motor_power_on && !motor_on_q && !brake_tmr.busy;
  endsequence

  sequence delay_begins_s;
    $fell(motor_power_on) && !servo_fault_flag && brake_time_q != '0;
  endsequence

  chk_fault_brake: assert property (servo_fault_flag |=> !release_q)
    else $error("brake released during a fault");

  chk_power_off_brake: assert property (power_gone_s |=> !release_q)
    else $error("brake released with motor power off");

  chk_brake_delay: assert property (delay_begins_s |=> brake_tmr.busy ##0 release_q)
    else $error("brake delay not started at power off");

  chk_delay_holds: assert property ((brake_tmr.busy && !servo_fault_flag) |=> release_q)
    else $error("brake dropped during its delay");

  chk_brake_polarity: assert property (
    ($stable(cfg_active_q) && !cfg_active_q[CFG_FUNC_SEL])
      |-> brake_pin_q == (release_q ^ cfg_active_q[CFG_BRAKE_POL]))
    else $error("brake pin polarity wrong");

  chk_alarm_code: assert property (
    ($stable(cfg_active_q) && cfg_active_q[CFG_FUNC_SEL])
      |-> {ready_pin_q, brake_pin_q, warn_pin_q} == $past(alarm_code))
    else $error("alarm code not on shared pins");

  chk_ready_cause: assert property (
    ready_q |-> $past(main_power_on && !hw_base_block && !servo_fault_flag))
    else $error("ready asserted without its conditions");

  chk_ready_polarity: assert property (
    ($stable(cfg_active_q) && !cfg_active_q[CFG_FUNC_SEL])
      |-> ready_pin_q == (ready_q ^ cfg_active_q[CFG_READY_POL]))
    else $error("ready pin polarity wrong");

  chk_err_held: assert property (
    (since_err_q >= 32'h2 && since_err_q <= HOLD_CYC + 32'h1) |-> warn_ind_q)
    else $error("error indication ended early");

  chk_err_ends: assert property (
    (since_err_q == HOLD_CYC + 32'h2 && !$past(warning_active)) |-> !warn_ind_q)
    else $error("error indication outlived its hold");

  chk_warn_follow: assert property (warning_active |=> warn_ind_q)
    else $error("warning not indicated");

  chk_warn_polarity: assert property (
    ($stable(cfg_active_q) && !cfg_active_q[CFG_FUNC_SEL])
      |-> warn_pin_q == (warn_ind_q ^ cfg_active_q[CFG_WARN_POL]))
    else $error("warning pin polarity wrong");

  chk_cfg_frozen: assert property (!restart_pulse |=> $stable(cfg_active_q))
    else $error("settings changed without restart");

  chk_err_restart: assert property (error_event |=> err_tmr.busy [*2])
    else $error("error hold not restarted");

  chk_irq_set_wins: assert property ((ev != '0) |=> ((irq_status_q & $past(ev)) == $past(ev)))
    else $error("event lost from status");

  chk_bus_one_wait: assert property (waitrequest |=> !waitrequest)
    else $error("bus held in wait beyond one cycle");

  chk_fault_pin_level: assert property (
    (servo_fault_flag && !cfg_active_q[CFG_FUNC_SEL])
      |=> brake_pin_q == $past(cfg_active_q[CFG_BRAKE_POL]))
    else $error("brake pin not at applied level during fault");

  chk_ready_blocked: assert property ((hw_base_block || !main_power_on) |=> !ready_q)
    else $error("ready asserted without main power or under base block");
endmodule

//--- relay_model.sv
`timescale 1ns/1ns
module relay_model (
  input wire logic [3:0] cfg,
  input wire logic warn_pin_closed,
  input wire logic brake_pin_closed,
  input wire logic ready_pin_closed,
  output logic brake_released,
  output logic ready_seen,
  output logic warn_seen
);
  // Host side undoes the active polarity before acting on a pin
  assign brake_released = brake_pin_closed ^ cfg[0];
  assign ready_seen = ready_pin_closed ^ cfg[1];
  assign warn_seen = warn_pin_closed ^ cfg[2];
endmodule

//--- drive_status_output_logic_bench.sv
`timescale 1ns/1ns
module drive_status_output_logic_bench;
  import status_out_pkg::*;
  localparam int TCK = 2;
  localparam int HOLD = 5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest, irq;
  logic fault = 1'b0, motor = 1'b0, mainp = 1'b0, hwbb = 1'b0;
  logic err_ev = 1'b0, warn = 1'b0;
  logic [2:0] code = 3'h0;
  logic warn_pin, brake_pin, ready_pin;
  logic [3:0] cfg_act = 4'h0;
  logic rel_brake, rel_ready, rel_warn;
  integer seed = 32'hc390;
  int bad_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  int d_list[2] = '{0, 3};

  always #5 clk = ~clk;

  drive_status_outputs #(.TICK_CYCLES(TCK), .ERR_HOLD_TICKS(HOLD)) DUT (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .servo_fault_flag(fault),
    .motor_power_on(motor), .main_power_on(mainp), .hw_base_block(hwbb),
    .error_event(err_ev), .warning_active(warn), .alarm_code(code),
    .warn_pin_closed(warn_pin), .brake_pin_closed(brake_pin),
    .ready_pin_closed(ready_pin)
  );

  relay_model host (
    .cfg(cfg_act), .warn_pin_closed(warn_pin), .brake_pin_closed(brake_pin),
    .ready_pin_closed(ready_pin), .brake_released(rel_brake),
    .ready_seen(rel_ready), .warn_seen(rel_warn)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One request held until waitrequest is seen low, then a spare cycle
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    // Only the watchdog ends a wait that never finishes
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Random power, block and fault levels against the host's view
  task automatic check_levels;
    logic m, h, f;
    for (int i = 0; i < 6; i++) begin
      m = 1'($random(seed));
      h = 1'($random(seed));
      f = 1'($random(seed));
      mainp <= m;
      hwbb <= h;
      fault <= f;
      motor <= 1'b1;
      tick(4);
      check(rel_ready, m & ~h & ~f);
      check(ready_pin, (m & ~h & ~f) ^ cfg_act[1]);
      check(brake_pin, !f ^ cfg_act[0]);
      check(rel_warn, 1'b0);
    end
    fault <= 1'b0;
    tick(2);
  endtask

  task automatic pulse_error;
    err_ev <= 1'b1;
    @(posedge clk);
    err_ev <= 1'b0;
  endtask

  initial begin
    int cnt;
    int d;
    tick(2);
    nrst <= 1'b1;
    bus(1'b0, OFF_CFG_STAGED, 0); check(rd, 32'h0);
    bus(1'b0, OFF_BRAKE_TIME, 0); check(rd, 32'h0);
    bus(1'b0, OFF_IRQ_MASK, 0); check(rd, 32'h0);
    bus(1'b0, 5'h1c, 0); check(rd, 32'h0);
    check_levels();
    cnt = 0;
    pulse_error();
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      cnt += warn_pin;
    end
    check(cnt, HOLD * TCK);
    pulse_error();
    tick(6);
    pulse_error();
    cnt = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      cnt += warn_pin;
    end
    check(cnt, HOLD * TCK + 1);
    warn <= 1'b1;
    tick(30);
    check(warn_pin, 1'b1);
    warn <= 1'b0;
    tick(3);
    check(warn_pin, 1'b0);
    foreach (d_list[k]) begin
      d = d_list[k];
      bus(1'b1, OFF_BRAKE_TIME, d);
      motor <= 1'b0;
      cnt = 0;
      for (int i = 0; i < 20; i++) begin
        @(posedge clk);
        cnt += brake_pin;
      end
      check(cnt >= d * TCK + 1 && cnt <= d * TCK + 3, 1'b1);
      motor <= 1'b1;
      tick(3);
    end
    bus(1'b1, OFF_IRQ_STATUS, 32'hf);
    fault <= 1'b1;
    tick(2);
    check(brake_pin, 1'b0);
    check(ready_pin, 1'b0);
    bus(1'b0, OFF_IRQ_STATUS, 0); check(rd[0], 1'b1);
    fault <= 1'b0;
    check(irq, 1'b0);
    bus(1'b1, OFF_IRQ_MASK, 32'h2);
    pulse_error();
    tick(3);
    check(irq, 1'b1);
    bus(1'b1, OFF_IRQ_STATUS, 32'hf);
    check(irq, 1'b0);
    bus(1'b1, OFF_CFG_STAGED, 32'h7);
    bus(1'b0, OFF_CFG_ACTIVE, 0); check(rd, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h1);
    cfg_act = 4'h7;
    bus(1'b0, OFF_CFG_ACTIVE, 0); check(rd, 32'h7);
    check_levels();
    pulse_error();
    tick(3);
    check(warn_pin, 1'b0);
    bus(1'b1, OFF_CFG_STAGED, 32'h8);
    bus(1'b1, OFF_CTRL, 32'h1);
    cfg_act = 4'h8;
    for (int i = 0; i < 5; i++) begin
      code <= 3'($random(seed));
      tick(3);
      check({ready_pin, brake_pin, warn_pin}, code);
    end
    // Mid-run reset falls back to factory settings
    nrst <= 1'b0;
    tick(2);
    check({ready_pin, brake_pin, warn_pin}, 3'h0);
    nrst <= 1'b1;
    cfg_act = 4'h0;
    bus(1'b0, OFF_CFG_ACTIVE, 0); check(rd, 32'h0);
    check(brake_pin, 1'b1);
    report_and_stop();
  end

  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end
endmodule
